/* File: sdp_datapath.sv */
// dual element simd compute datapath with interlock, exchange and universal registers
`timescale 1ns/1ps
module sdp_datapath
    import sdp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              modeWe,
    input  wire logic [MODE_W-1:0] modeData,
    output logic [MODE_W-1:0]      mode,
    input  wire logic              instrValid,
    input  wire sdp_instr_t        instr,
    output logic                   issueReady,
    input  wire logic              memValid,
    input  wire logic              memWrite,
    input  wire logic              memGen,
    input  wire logic [2:0]        memSel,
    input  wire logic [AW-1:0]     memMod,
    input  wire logic [3:0]        memReg,
    input  wire sdp_pair_t         memRdData,
    output logic [AW-1:0]          memAddr,
    output logic                   memAddrValid,
    output sdp_pair_t              memWrData,
    input  wire logic              agCfgWe,
    input  wire logic              agCfgGen,
    input  wire logic [2:0]        agCfgSel,
    input  wire logic [AW-1:0]     agBase,
    input  wire logic [AW-1:0]     agLen,
    input  wire logic [AW-1:0]     agIdx,
    input  wire sdp_pxop_t         xchgOp,
    input  wire logic [3:0]        xchgReg,
    input  wire logic [BUSW-1:0]   progBus,
    input  wire logic [BUSW-1:0]   dataBus,
    output logic [BUSW-1:0]        xchg,
    input  wire logic              ubValid,
    input  wire sdp_ubop_t         ubOp,
    input  wire logic [1:0]        ubSel,
    input  wire logic [31:0]       ubMask,
    output logic [NUB-1:0][31:0]   ubRegs,
    output logic                   ubTest,
    input  wire logic [3:0]        rdReg,
    output sdp_pair_t              rdData,
    output sdp_pair_t              mrOut
);
    logic          take;
    logic          dBank;
    logic [2:0]    busy [NREG];
    logic [DW-1:0] rdW [2];
    logic [DW-1:0] stW [2];
    logic [DW-1:0] mrW [2];
    logic [DW-1:0] xchgSrc;
    logic [AW-1:0] agAddr [2];
    logic          genLast;

    assign dBank = mode[MB_ALT_DATA]; // [RQ10]

    // a source or destination still in flight blocks issue
    assign issueReady = (busy[instr.srcA] == 3'h0) && (busy[instr.srcB] == 3'h0)
        && (instr.aluOp == ALU_NOP || busy[instr.dstA] == 3'h0)
        && (!instr.mulEn || busy[instr.dstM] == 3'h0); // [RQ8]
    assign take = instrValid && issueReady;

    // busy counters; waw is stalled above so a new count never overwrites a live one
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < NREG; i++)
                busy[i] <= 3'h0;
        end else begin
            for (int i = 0; i < NREG; i++)
                if (busy[i] != 3'h0)
                    busy[i] <= busy[i] - 3'h1;
            if (take && instr.aluOp != ALU_NOP)
                busy[instr.dstA] <= sdp_lat(instr.fmt, 1'b0) - 3'h1; // [RQ6] [RQ7]
            if (take && instr.mulEn)
                busy[instr.dstM] <= sdp_lat(instr.fmt, 1'b1) - 3'h1; // [RQ7]
        end
    end

    // one element per pass: same instruction, own register file and operands
    for (genvar e = 0; e < 2; e++) begin : g_pe
        logic [DW-1:0]          rf [2*NREG];
        logic [2*DW-1:0]        mr [2];
        logic [DW-1:0]          a, b, aluRes;
        logic signed [2*FXW-1:0] p64;
        logic                   en;

        assign en  = (e == 0) || mode[MB_SECOND]; // [RQ1]
        assign a   = rf[{dBank, instr.srcA}]; // [RQ2]
        assign b   = rf[{dBank, instr.srcB}];
        assign p64 = $signed(a[FXW-1:0]) * $signed(b[FXW-1:0]);
        assign rdW[e] = rf[{dBank, rdReg}];
        assign stW[e] = rf[{dBank, memReg}];
        assign mrW[e] = mr[mode[MB_ALT_MR]][DW-1:0];

        // float arithmetic is integer on the low word; sign ops honour the format
        always_comb begin
            aluRes = a;
            unique case (instr.aluOp)
                ALU_NOP, ALU_PASS: aluRes = a;
                ALU_ADD: aluRes = {{PADW{1'b0}}, a[FXW-1:0] + b[FXW-1:0]};
                ALU_SUB: aluRes = {{PADW{1'b0}}, a[FXW-1:0] - b[FXW-1:0]};
                ALU_NEG: begin
                    if (instr.fmt == FMT_FIX)
                        aluRes = {{PADW{1'b0}}, -a[FXW-1:0]};
                    else
                        aluRes[sdp_sign(instr.fmt)] = ~a[sdp_sign(instr.fmt)]; // [RQ4]
                end
                ALU_ABS: begin
                    if (instr.fmt == FMT_FIX)
                        aluRes = {{PADW{1'b0}}, a[FXW-1] ? -a[FXW-1:0] : a[FXW-1:0]};
                    else
                        aluRes[sdp_sign(instr.fmt)] = 1'b0; // [RQ4]
                end
                default: aluRes = a;
            endcase
        end

        // register file writes; alu beats multiplier beats load beats exchange
        always_ff @(posedge clk) begin
            if (e == 0 && xchgOp == XC_TO_RF)
                rf[{dBank, xchgReg}] <= xchg[DW-1:0]; // [RQ12]
            if (memValid && !memWrite && en)
                rf[{dBank, memReg}] <= (e == 0) ? memRdData.x : memRdData.y; // [RQ3]
            if (take && en && instr.mulEn)
                rf[{dBank, instr.dstM}] <= {{PADW{1'b0}}, p64[FXW-1:0]}; // [RQ5]
            if (take && en && instr.aluOp != ALU_NOP)
                rf[{dBank, instr.dstA}] <= aluRes; // [RQ5] [RQ9]
        end

        // multiplier result register, banked
        always_ff @(posedge clk) begin
            if (!nrst) begin
                mr[0] <= '0;
                mr[1] <= '0;
            end else if (take && en && instr.mulEn) begin
                mr[mode[MB_ALT_MR]] <= {{(2*DW-2*FXW){p64[2*FXW-1]}}, p64}; // [RQ10]
            end
        end
    end

    // two generators, half of the buffer sets each
    for (genvar g = 0; g < 2; g++) begin : g_ag
        sdp_addr_gen u_ag (
            .clk      (clk),
            .nrst     (nrst),
            .altBank  (mode[MB_ALT_AG]),
            .cfgWe    (agCfgWe && agCfgGen == g),
            .cfgSel   (agCfgSel),
            .cfgBase  (agBase),
            .cfgLen   (agLen),
            .cfgIdx   (agIdx),
            .genValid (memValid && memGen == g),
            .genSel   (memSel),
            .genMod   (memMod),
            .addr     (agAddr[g])
        ); // [RQ13]
    end
    assign memAddr = agAddr[genLast];
    assign xchgSrc = rdW[0];

    // transfer side: one access moves a word per enabled element
    always_ff @(posedge clk) begin
        if (!nrst) begin
            genLast      <= 1'b0;
            memAddrValid <= 1'b0;
            memWrData    <= '0;
        end else begin
            memAddrValid <= memValid;
            if (memValid)
                genLast <= memGen;
            if (memValid && memWrite) begin
                memWrData.x <= stW[0];
                memWrData.y <= mode[MB_SECOND] ? stW[1] : '0; // [RQ3]
            end
        end
    end

    // mode control; universal register copy counts as a control write
    always_ff @(posedge clk) begin
        if (!nrst)
            mode <= MODE_RST; // [RQ10]
        else if (ubValid && ubOp == UB_MODE)
            mode <= ubRegs[ubSel]; // [RQ11]
        else if (modeWe)
            mode <= modeData;
    end

    // universal bit registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ubRegs <= '0;
            ubTest <= 1'b0;
        end else if (ubValid) begin
            unique case (ubOp)
                UB_LOAD: ubRegs[ubSel] <= ubMask;
                UB_SET:  ubRegs[ubSel] <= ubRegs[ubSel] | ubMask; // [RQ11]
                UB_CLR:  ubRegs[ubSel] <= ubRegs[ubSel] & ~ubMask;
                UB_TGL, UB_XOR: ubRegs[ubSel] <= ubRegs[ubSel] ^ ubMask;
                UB_TST:  ubTest <= (ubRegs[ubSel] & ubMask) == ubMask;
                UB_MODE: ubTest <= ubTest;
                default: ubTest <= ubTest;
            endcase
        end
    end

    // exchange register, zero-extends the narrow side
    always_ff @(posedge clk) begin
        if (!nrst)
            xchg <= '0;
        else begin
            unique case (xchgOp)
                XC_PROG: xchg <= progBus; // [RQ12]
                XC_DATA: xchg <= dataBus;
                XC_FROM_RF: xchg <= {{(BUSW-DW){1'b0}}, xchgSrc}; // [RQ12]
                XC_NONE, XC_TO_RF: xchg <= xchg;
                default: xchg <= xchg;
            endcase
        end
    end

    // readback of both elements and active multiplier results
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdData <= '0;
            mrOut  <= '0;
        end else begin
            rdData.x <= rdW[0];
            rdData.y <= rdW[1];
            mrOut.x  <= mrW[0];
            mrOut.y  <= mrW[1];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_second_off_store: assert property (memValid && memWrite && !mode[MB_SECOND] // [RQ1]
        |=> memWrData.y == '0)
        else $error("disabled second element drove store data");
    a_simd_store_y: assert property (memValid && memWrite && mode[MB_SECOND] // [RQ3]
        |=> memWrData.y == $past(stW[1]))
        else $error("simd store missing second word");
    a_fix_one_cycle: assert property (take && instr.fmt == FMT_FIX // [RQ6]
        && instr.aluOp != ALU_NOP |=> busy[$past(instr.dstA)] == 3'h0)
        else $error("fixed result not ready after one cycle");
    a_fp_dep_two: assert property (take && instr.fmt == FMT_SP && instr.aluOp != ALU_NOP // [RQ6]
        |=> busy[$past(instr.dstA)] == 3'h1 ##1 busy[$past(instr.dstA, 2)] == 3'h0)
        else $error("float dependency not two cycles");
    a_dp_mul_six: assert property (take && instr.fmt == FMT_DP && instr.mulEn // [RQ7]
        |=> busy[$past(instr.dstM)] == 3'h5)
        else $error("double multiply latency wrong");
    a_stall_on_busy: assert property (busy[instr.srcA] != 3'h0 |-> !issueReady) // [RQ8]
        else $error("issue allowed on busy operand");
    a_busy_drain: assert property (busy[0] != 3'h0 |=> busy[0] == $past(busy[0]) - 3'h1) // [RQ8]
        else $error("busy counter not draining");
    a_ub_set_bits: assert property (ubValid && ubOp == UB_SET // [RQ11]
        |=> (ubRegs[$past(ubSel)] & $past(ubMask)) == $past(ubMask))
        else $error("universal set lost bits");
    a_xchg_widen: assert property (xchgOp == XC_FROM_RF // [RQ12]
        |=> xchg[BUSW-1:DW] == '0 && xchg[DW-1:0] == $past(xchgSrc))
        else $error("exchange width handling wrong");
    a_primary_reset: assert property ($past(!nrst) |-> mode == MODE_RST) // [RQ10]
        else $error("mode not primary after reset");
    a_addr_follows: assert property (memValid |=> memAddrValid) // [RQ14]
        else $error("address not presented");

    c_simd_multi: cover property (take && mode[MB_SECOND] && instr.mulEn && instr.aluOp != ALU_NOP);
    c_dp_stall: cover property (instrValid && !issueReady ##5 instrValid && issueReady);
    c_alt_bank: cover property (take && mode[MB_ALT_DATA] && mode[MB_ALT_MR]);
endmodule

/* File: sdp_pkg.sv */
// package: widths, mode fields, latencies and carriers of the dual element simd datapath
// Function
// (RQ1) The first compute element always works and the second works only while its enable bit is set.
// (RQ2) With the second element enabled each instruction goes to both elements, each on its own operands.
// (RQ3) With the second element enabled each generator-driven transfer carries one word per element.
// (RQ4) The units take fixed, single, extended and double precision formats at their widths; the code computes on the low 32 bits except for sign ops.
// (RQ5) One instruction runs an alu and a multiplier operation together, in both elements when enabled.
// (RQ6) Every operation takes one cycle, and a float result used by a dependent instruction takes two.
// (RQ7) Double precision operations complete with a latency between two and six cycles.
// (RQ8) Issue checks operand dependencies and stalls until the operand is available.
// (RQ9) Each element has a 32-word register file of sixteen primary and sixteen alternate words.
// (RQ10) Data, generator and multiplier result registers have alternate banks, primary after reset.
// (RQ11) Four universal registers support set, clear, toggle, test and xor bit operations.
// (RQ12) The bus exchange register passes data between both buses and the register file in width.
// (RQ13) The two address generators hold sixteen primary and sixteen alternate buffer sets.
// (RQ14) The generators wrap a circular pointer back into its buffer with no software help.
// (RQ15) Buffer base and end may sit at any address with no alignment.
// (RQ16) A pointer leaving the buffer gets the length added or subtracted to land inside again.
package sdp_pkg;
    localparam int DW     = 40;   // register file word
    localparam int FXW    = 32;   // fixed and single word
    localparam int PADW   = DW - FXW;
    localparam int BUSW   = 64;   // program and data bus width
    localparam int NREG   = 16;   // words per bank
    localparam int NSET   = 8;    // buffer sets per generator and bank
    localparam int NUB    = 4;
    localparam int AW     = 32;
    localparam int MODE_W = 32;
    // mode control register fields
    localparam int MB_SECOND   = 0;
    localparam int MB_ALT_DATA = 1;
    localparam int MB_ALT_AG   = 2;
    localparam int MB_ALT_MR   = 3;
    localparam logic [MODE_W-1:0] MODE_RST = 32'h0000_0000;
    // sign bit positions per format
    localparam int SIGN_SP  = 31;
    localparam int SIGN_EXT = 39;
    // result latency in cycles, counted from the issue edge
    localparam logic [2:0] LAT_FIX    = 3'h1;
    localparam logic [2:0] LAT_FP     = 3'h2;
    localparam logic [2:0] LAT_DP_ALU = 3'h2;
    localparam logic [2:0] LAT_DP_MUL = 3'h6;

    typedef enum logic [1:0] {FMT_FIX = 2'h0, FMT_SP = 2'h1, FMT_EXT = 2'h3, FMT_DP = 2'h2} sdp_fmt_t;
    typedef enum logic [2:0] {ALU_NOP, ALU_ADD, ALU_SUB, ALU_PASS, ALU_NEG, ALU_ABS} sdp_alu_t;
    typedef enum logic [2:0] {UB_LOAD, UB_SET, UB_CLR, UB_TGL, UB_TST, UB_XOR, UB_MODE} sdp_ubop_t;
    typedef enum logic [2:0] {XC_NONE, XC_PROG, XC_DATA, XC_FROM_RF, XC_TO_RF} sdp_pxop_t;

    typedef struct packed {
        sdp_alu_t   aluOp;
        logic       mulEn;
        sdp_fmt_t   fmt;
        logic [3:0] dstA;
        logic [3:0] dstM;
        logic [3:0] srcA;
        logic [3:0] srcB;
    } sdp_instr_t;

    typedef struct packed {
        logic [DW-1:0] y;
        logic [DW-1:0] x;
    } sdp_pair_t;

    // result latency per format and unit
    function automatic logic [2:0] sdp_lat(input sdp_fmt_t f, input logic isMul);
        logic [2:0] l;
        l = LAT_FP;
        if (f == FMT_FIX)
            l = LAT_FIX;
        else if (f == FMT_DP)
            l = isMul ? LAT_DP_MUL : LAT_DP_ALU;
        return l;
    endfunction

    function automatic int sdp_sign(input sdp_fmt_t f);
        return (f == FMT_EXT || f == FMT_DP) ? SIGN_EXT : SIGN_SP;
    endfunction
endpackage

/* File: sdp_addr_gen.sv */
// address generator with banked circular buffer sets
`timescale 1ns/1ps
module sdp_addr_gen
    import sdp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          altBank,
    input  wire logic          cfgWe,
    input  wire logic [2:0]    cfgSel,
    input  wire logic [AW-1:0] cfgBase,
    input  wire logic [AW-1:0] cfgLen,
    input  wire logic [AW-1:0] cfgIdx,
    input  wire logic          genValid,
    input  wire logic [2:0]    genSel,
    input  wire logic [AW-1:0] genMod,
    output logic [AW-1:0]      addr
);
    logic [AW-1:0] idxR  [2*NSET];
    logic [AW-1:0] baseR [2*NSET];
    logic [AW-1:0] lenR  [2*NSET];
    logic [AW-1:0] cur, sum, hi, next_idx;

    // active bank picks half of the sets
    assign cur = idxR[{altBank, genSel}];
    assign sum = cur + genMod;
    assign hi  = baseR[{altBank, genSel}] + lenR[{altBank, genSel}];

    // length zero means linear addressing; no alignment is assumed anywhere
    always_comb begin
        next_idx = sum; // [RQ15]
        if (lenR[{altBank, genSel}] != '0) begin
            if (!genMod[AW-1] && sum >= hi)
                next_idx = sum - lenR[{altBank, genSel}]; // [RQ14] [RQ16]
            else if (genMod[AW-1] && sum < baseR[{altBank, genSel}])
                next_idx = sum + lenR[{altBank, genSel}]; // [RQ16]
        end
    end

    // sixteen primary and sixteen alternate sets across both generators
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < 2*NSET; i++) begin
                idxR[i]  <= '0;
                baseR[i] <= '0;
                lenR[i]  <= '0;
            end
            addr <= '0;
        end else begin
            if (cfgWe) begin
                idxR[{altBank, cfgSel}]  <= cfgIdx; // [RQ13]
                baseR[{altBank, cfgSel}] <= cfgBase;
                lenR[{altBank, cfgSel}]  <= cfgLen;
            end
            if (genValid) begin
                addr                     <= cur; // post-modify
                idxR[{altBank, genSel}]  <= next_idx; // [RQ14]
            end
        end
    end
endmodule

/* File: sdp_mem_model.sv */
// memory side model: serves load pairs and records store pairs
`timescale 1ns/1ps
module sdp_mem_model
    import sdp_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      memValid,
    input  wire logic      memAddrValid,
    input  wire sdp_pair_t memWrData,
    input  wire sdp_pair_t loadVal,
    output sdp_pair_t      memRdData,
    output sdp_pair_t      lastStore
);
    sdp_pair_t held;
    // both words ride one access; off-cycle the bus shows the inverse so stale data never matches
    assign memRdData = memValid ? loadVal : ~held;
    // remember the served pair and the last pair written back
    always_ff @(posedge clk) begin
        if (memValid)
            held <= loadVal;
        if (memAddrValid)
            lastStore <= memWrData;
    end
endmodule

/* File: dual_element_simd_datapath_bench.sv */
// self-checking bench for the dual element simd datapath
`timescale 1ns/1ps
module dual_element_simd_datapath_bench;
    import sdp_pkg::*;
    logic clk, nrst, modeWe, instrValid, memValid, memWrite, memGen, agCfgWe, agCfgGen;
    logic ubValid, issueReady, memAddrValid, ubTest;
    logic [MODE_W-1:0] modeData, mode;
    logic [2:0] memSel, agCfgSel;
    logic [AW-1:0] memMod, memAddr, agBase, agLen, agIdx;
    logic [3:0] memReg, xchgReg, rdReg;
    logic [BUSW-1:0] progBus, dataBus, xchg;
    logic [1:0] ubSel;
    logic [31:0] ubMask;
    logic [NUB-1:0][31:0] ubRegs;
    sdp_instr_t instr;
    sdp_pair_t memRdData, memWrData, rdData, mrOut, loadVal, lastStore;
    sdp_pxop_t xchgOp;
    sdp_ubop_t ubOp;
    logic [15:0] seed;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    localparam int STL[5] = '{0, 1, 1, 1, 5};
    localparam sdp_fmt_t FMTS[5] = '{FMT_FIX, FMT_SP, FMT_EXT, FMT_DP, FMT_DP};
    localparam logic [31:0] MODS[3] = '{32'h3, 32'hffff_fffe, 32'h0};
    localparam logic [31:0] ADRS[3] = '{32'h106, 32'h104, 32'h107};
    localparam sdp_ubop_t UBOPS[7] = '{UB_LOAD, UB_SET, UB_CLR, UB_TGL, UB_XOR, UB_TST, UB_TST};
    localparam logic [31:0] UBM[7] = '{32'hf0, 32'h0f, 32'h30, 32'h03, 32'h0c, 32'hc0, 32'h0f};
    localparam logic [31:0] UBE[7] = '{32'hf0, 32'hff, 32'hcf, 32'hcc, 32'hc0, 32'hc0, 32'hc0};

    sdp_datapath dut (.clk, .nrst, .modeWe, .modeData, .mode, .instrValid, .instr, .issueReady,
        .memValid, .memWrite, .memGen, .memSel, .memMod, .memReg, .memRdData, .memAddr,
        .memAddrValid, .memWrData, .agCfgWe, .agCfgGen, .agCfgSel, .agBase, .agLen, .agIdx,
        .xchgOp, .xchgReg, .progBus, .dataBus, .xchg, .ubValid, .ubOp, .ubSel, .ubMask,
        .ubRegs, .ubTest, .rdReg, .rdData, .mrOut);
    sdp_mem_model u_mem (.clk, .memValid, .memAddrValid, .memWrData, .loadVal, .memRdData,
        .lastStore);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic rnd(output logic [31:0] v);
        seed = lfsr(seed);
        v[15:0] = seed;
        seed = lfsr(seed);
        v[31:16] = seed;
    endtask

    // fixed data sits in the low word with the top byte clear
    function automatic logic [DW-1:0] expAlu(input logic sub, input logic [31:0] a, b);
        logic [31:0] r;
        r = sub ? a - b : a + b;
        return {8'h00, r};
    endfunction

    function automatic sdp_instr_t mk(input sdp_alu_t op, input logic mul, input sdp_fmt_t f,
                                      input logic [3:0] da, dm, sa, sb);
        return '{op, mul, f, da, dm, sa, sb};
    endfunction

    // every task is entered just after a rising edge and leaves just after one
    task automatic mem(input logic wr, gen, input logic [2:0] sel, input logic [AW-1:0] md,
                       input logic [3:0] r, input sdp_pair_t v, input logic [AW-1:0] ea);
        {memValid, memWrite, memGen, memSel, memMod, memReg} <= {1'b1, wr, gen, sel, md, r};
        loadVal <= v;
        @(posedge clk);
        memValid <= 1'b0;
        #1;
        chk("memAddrValid", 64'h1, {63'h0, memAddrValid});
        chk("memAddr", {32'h0, ea}, {32'h0, memAddr});
        @(posedge clk);
    endtask

    task automatic cfg(input logic gen, input logic [2:0] sel, input logic [AW-1:0] b, l, i);
        {agCfgWe, agCfgGen, agCfgSel, agBase, agLen, agIdx} <= {1'b1, gen, sel, b, l, i};
        @(posedge clk);
        agCfgWe <= 1'b0;
        @(posedge clk);
    endtask

    task automatic setMode(input logic [31:0] v);
        {modeWe, modeData} <= {1'b1, v};
        @(posedge clk);
        modeWe <= 1'b0;
        @(posedge clk);
        chk("mode", {32'h0, v}, {32'h0, mode});
    endtask

    task automatic ub(input sdp_ubop_t op, input logic [1:0] s, input logic [31:0] m);
        ubOp <= op;
        {ubValid, ubSel, ubMask} <= {1'b1, s, m};
        @(posedge clk);
        ubValid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic xchgDo(input sdp_pxop_t op, input logic [3:0] r);
        xchgOp <= op;
        {xchgReg, rdReg} <= {r, r};
        @(posedge clk);
        xchgOp <= XC_NONE;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] r, output sdp_pair_t v);
        rdReg <= r;
        @(posedge clk);
        #1;
        v = rdData;
        @(posedge clk);
    endtask

    // holds the instruction until taken; n counts the refused edges
    task automatic iss(input sdp_instr_t i, output int n);
        instrValid <= 1'b1;
        instr <= i;
        n = 0;
        @(posedge clk);
        while (issueReady !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
    endtask

    task automatic quiet();
        instrValid <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        sdp_pair_t v;
        logic [31:0] r[4];
        logic [63:0] p, q;
        logic sim;
        int n;
        {nrst, modeWe, instrValid, memValid, memWrite, memGen, agCfgWe, agCfgGen, ubValid} = '0;
        {modeData, memSel, agCfgSel, memMod, agBase, agLen, agIdx, memReg, xchgReg, rdReg} = '0;
        {progBus, dataBus, ubSel, ubMask} = '0;
        instr = '0;
        loadVal = '0;
        xchgOp = XC_NONE;
        ubOp = UB_LOAD;
        seed = 16'hd422;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk("mode", 64'h0, {32'h0, mode});
        chk("xchg", 64'h0, xchg);
        chk("ubRegs", 64'h0, {ubRegs[1], ubRegs[0]});
        chk("issueReady", 64'h1, {63'h0, issueReady});
        @(posedge clk);
        // one index, two banks, two values
        ld_bank: begin
            mem(1'b0, 1'b0, 3'h0, 32'h0, 4'h8, {40'h11, 40'h22}, 32'h0);
            setMode(32'h2);
            mem(1'b0, 1'b0, 3'h0, 32'h0, 4'h8, {40'h33, 40'h44}, 32'h0);
            rd(4'h8, v);
            chk("altReg", 64'h44, {24'h0, v.x});
            setMode(32'h0);
            rd(4'h8, v);
            chk("priReg", 64'h22, {24'h0, v.x});
        end
        // random alu plus multiply, alternating simd and single element
        for (int k = 0; k < 8; k++) begin
            for (int j = 0; j < 4; j++)
                rnd(r[j]);
            sim = ~k[0];
            setMode(32'h1);
            mem(1'b0, 1'b0, 3'h0, 32'h0, 4'h1, {8'h0, r[2], 8'h0, r[0]}, 32'h0);
            mem(1'b0, 1'b0, 3'h0, 32'h0, 4'h2, {8'h0, r[3], 8'h0, r[1]}, 32'h0);
            mem(1'b0, 1'b0, 3'h0, 32'h0, 4'h4, {40'h5a, 40'h0}, 32'h0);
            setMode({31'h0, sim});
            iss(mk(k[1] ? ALU_SUB : ALU_ADD, 1'b1, FMT_FIX, 4'h4, 4'h5, 4'h1, 4'h2), n);
            quiet();
            rd(4'h4, v);
            chk("aluX", expAlu(k[1], r[0], r[1]), v.x);
            chk("aluY", sim ? expAlu(k[1], r[2], r[3]) : 40'h5a, v.y);
            p = $signed(r[0]) * $signed(r[1]);
            q = $signed(r[2]) * $signed(r[3]);
            chk("mrX", p[39:0], mrOut.x);
            if (sim)
                chk("mrY", q[39:0], mrOut.y);
            rd(4'h5, v);
            chk("mulX", {8'h0, p[31:0]}, v.x);
            if (sim)
                chk("mulY", {8'h0, q[31:0]}, v.y);
            mem(1'b1, 1'b0, 3'h0, 32'h0, 4'h4, '0, 32'h0);
            quiet();
            chk("storeY", sim ? expAlu(k[1], r[2], r[3]) : 40'h0, lastStore.y);
            chk("storeX", expAlu(k[1], r[0], r[1]), lastStore.x);
        end
        // untouched alternate product bank still reads zero
        setMode(32'h8);
        quiet();
        chk("mrAlt", 64'h0, {24'h0, mrOut.x});
        // sign ops per format on the last random operand
        iss(mk(ALU_NEG, 1'b0, FMT_EXT, 4'ha, 4'ha, 4'h1, 4'h2), n);
        iss(mk(ALU_ABS, 1'b0, FMT_FIX, 4'hb, 4'hb, 4'h1, 4'h2), n);
        quiet();
        rd(4'ha, v);
        chk("negExt", {32'h80, r[0]}, {24'h0, v.x});
        rd(4'hb, v);
        chk("absFix", {32'h0, r[0][31] ? -r[0] : r[0]}, {24'h0, v.x});
        // dependent issue right behind each format and unit
        for (int k = 0; k < 5; k++) begin
            iss(mk(k == 4 ? ALU_NOP : ALU_ADD, k == 4, FMTS[k], 4'h3, 4'h3, 4'h1, 4'h2), n);
            iss(mk(ALU_PASS, 1'b0, FMT_FIX, 4'h9, 4'h9, 4'h3, 4'h2), n);
            quiet();
            chk("stalls", STL[k], n);
        end
        // unaligned buffer, forward and backward wrap, then the other generator bank
        cfg(1'b1, 3'h3, 32'h103, 32'h5, 32'h106);
        for (int k = 0; k < 3; k++)
            mem(1'b0, 1'b1, 3'h3, MODS[k], 4'h7, '0, ADRS[k]);
        setMode(32'h4);
        mem(1'b0, 1'b1, 3'h3, 32'h0, 4'h7, '0, 32'h0);
        setMode(32'h0);
        mem(1'b0, 1'b1, 3'h3, 32'h0, 4'h7, '0, 32'h107);
        // bit operations on one universal register
        for (int k = 0; k < 7; k++) begin
            ub(UBOPS[k], 2'h2, UBM[k]);
            chk("ubReg", {32'h0, UBE[k]}, {32'h0, ubRegs[2]});
            if (k > 4)
                chk("ubTest", {63'h0, k == 5}, {63'h0, ubTest});
        end
        ub(UB_LOAD, 2'h1, 32'h1);
        ub(UB_MODE, 2'h1, 32'h0);
        chk("ubMode", 64'h1, {32'h0, mode});
        // exchange register between both buses and the register file
        progBus <= 64'h0123_4567_89ab_cdef;
        dataBus <= 64'hfedc_ba98_7654_3210;
        xchgDo(XC_PROG, 4'h0);
        chk("xchgProg", 64'h0123_4567_89ab_cdef, xchg);
        xchgDo(XC_DATA, 4'h6);
        chk("xchgData", 64'hfedc_ba98_7654_3210, xchg);
        xchgDo(XC_TO_RF, 4'h6);
        rd(4'h6, v);
        chk("xchgToRf", 64'h98_7654_3210, {24'h0, v.x});
        xchgDo(XC_FROM_RF, 4'h6);
        chk("xchgFromRf", 64'h98_7654_3210, xchg);
        stop_test();
    end
endmodule
